// file: logic/smp_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   push is refused while full, so back-pressure reaches the bus
`timescale 1ns/100ps
module smp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // queue ports
    smp_fifo_if.fifo   q
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             full;
    logic             empty;

    assign empty        = (wr_ptr_reg == rd_ptr_reg);
    assign full         = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
                          && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign q.push_ready = !full;
    assign q.pop_valid  = !empty;
    assign q.pop_data   = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge pclk)
    begin
        if (q.push_valid && !full)
        begin
            mem[wr_ptr_reg[AW-1:0]] <= q.push_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (q.push_valid && !full)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (q.pop_ready && !empty)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    chk_fifo_no_overrun: assert property (@(posedge pclk) disable iff (!presetn)
        full && q.push_valid |=> wr_ptr_reg == $past(wr_ptr_reg))
        else $error("fifo accepted a word while full");

endmodule // smp_fifo

// file: logic/smp_fifo_if.sv
// Purpose: valid/ready carrier between the register side and the fifo
// Assumes: one clock domain
// Notes:   push side fills, pop side drains
`timescale 1ns/100ps
interface smp_fifo_if #(parameter int WIDTH = 8);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport fifo (
        input  push_valid,
        output push_ready,
        input  push_data,
        output pop_valid,
        input  pop_ready,
        output pop_data
    );

    modport user (
        output push_valid,
        input  push_ready,
        output push_data,
        input  pop_valid,
        output pop_ready,
        input  pop_data
    );
endinterface

// file: logic/smp_pin_ctrl.sv
// Purpose: host-facing pin logic: startup straps, status outputs, uart pins
// Assumes: pin inputs synchronous to pclk; software sets mode over APB
// Notes:   output enables are active low; every pin floats in reset
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps

module smp_pin_ctrl #(
    parameter int unsigned STARTUP_CYCLES = smp_pkg::STARTUP_CYCLES,
    parameter int unsigned FLASH_CYCLES   = smp_pkg::FLASH_CYCLES,
    parameter int          FIFO_DEPTH     = 8
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // strap and modem inputs
    input  wire logic        switch0_n,
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        rxd,
    // green status / serial default strap, two-way
    input  wire logic        green_in,
    output logic             green_out,
    output logic             green_oe_n,
    // status and uart outputs, sharing one enable
    output logic             red_n,
    output logic             blue_n,
    output logic             txd,
    output logic             rts_n,
    output logic             dtr_n,
    output logic             transceiver_select_0,
    output logic             transceiver_select_1,
    output logic             pins_oe_n,
    // towards the firmware side
    output logic             connect_req,
    output logic             factory_restore,
    output logic             serial_default
);

    smp_fifo_if #(.WIDTH(8)) txq ();

    logic [smp_pkg::CTRL_WIDTH-1:0] ctrl_reg;
    logic [15:0]                    baud_div_reg;
    logic [31:0]                    prdata_reg;
    logic [31:0]                    startup_cnt_reg;
    logic                           startup_done_reg;
    logic                           serdef_reg;
    logic                           factory_reg;
    logic [31:0]                    flash_cnt_reg;
    logic [15:0]                    baud_cnt_reg;
    logic                           baud_tick;
    smp_pkg::smp_tx_state_t         tx_state_reg;
    logic [9:0]                     tx_shift_reg;
    logic [3:0]                     tx_bits_reg;
    logic                           tx_start;
    logic                           flashing;
    logic                           green_reg;
    logic                           red_reg;
    logic                           blue_reg;
    logic                           txd_reg;
    logic                           rts_reg;
    logic                           dtr_reg;
    logic                           sel0_reg;
    logic                           sel1_reg;
    logic                           drive_reg;
    logic                           setup_phase;
    logic                           access;
    logic                           mapped;
    logic                           tx_wr;
    logic                           window_end;
    smp_pkg::smp_mode_t             mode;

    assign mode        = smp_pkg::smp_mode_t'(ctrl_reg[smp_pkg::CTRL_MODE_LSB +: 2]);
    assign setup_phase = psel && !penable;
    assign mapped      = (paddr == smp_pkg::CTRL_OFS) || (paddr == smp_pkg::BAUD_OFS)
                         || (paddr == smp_pkg::TXDATA_OFS) || (paddr == smp_pkg::STATUS_OFS);
    assign tx_wr       = psel && penable && pwrite && (paddr == smp_pkg::TXDATA_OFS);
    // a data write waits while the queue is full: back-pressure to the bus
    assign pready      = tx_wr ? txq.push_ready : 1'b1;
    assign access      = psel && penable && pready;
    assign pslverr     = psel && penable && !mapped;
    assign prdata      = prdata_reg;
    assign window_end  = !startup_done_reg && (startup_cnt_reg == STARTUP_CYCLES - 1);

    assign txq.push_valid = tx_wr;
    assign txq.push_data  = pwdata[7:0];

    smp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_txq (
        .pclk    (pclk),
        .presetn (presetn),
        .q       (txq.fifo)
    );

    // startup window, timed from reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            startup_cnt_reg  <= 32'h0000_0000;
            startup_done_reg <= 1'b0;
        end
        else if (!startup_done_reg)
        begin
            startup_cnt_reg  <= startup_cnt_reg + 32'h0000_0001;
            startup_done_reg <= window_end;
        end
    end

    // straps are latched here only in the last window cycle; connect_req keeps reading switch0_n after it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serdef_reg  <= 1'b0;
            factory_reg <= 1'b0;
        end
        else if (window_end)
        begin
            serdef_reg  <= !green_in;
            factory_reg <= !green_in && !switch0_n;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg     <= smp_pkg::CTRL_RESET;
            baud_div_reg <= smp_pkg::BAUD_DIV_DEFAULT;
        end
        else if (window_end && !green_in)
        begin
            baud_div_reg <= smp_pkg::BAUD_DIV_DEFAULT;
            if (!switch0_n)
            begin
                ctrl_reg <= smp_pkg::CTRL_RESET;
            end
        end
        else if (access && pwrite)
        begin
            if (paddr == smp_pkg::CTRL_OFS)
            begin
                ctrl_reg <= pwdata[smp_pkg::CTRL_WIDTH-1:0];
            end
            if (paddr == smp_pkg::BAUD_OFS)
            begin
                baud_div_reg <= pwdata[15:0];
            end
        end
    end

    // read data is captured in the setup cycle, so access needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else if (setup_phase)
        begin
            prdata_reg <= 32'h0000_0000;
            unique case (paddr)
                smp_pkg::CTRL_OFS:
                begin
                    prdata_reg[smp_pkg::CTRL_WIDTH-1:0] <= ctrl_reg;
                end
                smp_pkg::BAUD_OFS:
                begin
                    prdata_reg[15:0] <= baud_div_reg;
                end
                smp_pkg::STATUS_OFS:
                begin
                    prdata_reg[smp_pkg::STAT_DONE_BIT]    <= startup_done_reg;
                    prdata_reg[smp_pkg::STAT_SERDEF_BIT]  <= serdef_reg;
                    prdata_reg[smp_pkg::STAT_FACTORY_BIT] <= factory_reg;
                    prdata_reg[smp_pkg::STAT_CONNREQ_BIT] <= connect_req;
                    prdata_reg[smp_pkg::STAT_CTS_BIT]     <= !cts_n;
                    prdata_reg[smp_pkg::STAT_DSR_BIT]     <= !dsr_n;
                    prdata_reg[smp_pkg::STAT_RXD_BIT]     <= rxd;
                    prdata_reg[smp_pkg::STAT_EMPTY_BIT]   <= !txq.pop_valid;
                    prdata_reg[smp_pkg::STAT_FULL_BIT]    <= !txq.push_ready;
                    prdata_reg[smp_pkg::STAT_BUSY_BIT]    <= (tx_state_reg == smp_pkg::TX_SHIFT);
                end
                default:
                begin
                    prdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // bit-rate divider, one-cycle enable pulse
    assign baud_tick = (baud_cnt_reg == 16'h0000);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            baud_cnt_reg <= 16'h0000;
        end
        else if (tx_start || baud_tick)
        begin
            baud_cnt_reg <= baud_div_reg - 16'h0001;
        end
        else
        begin
            baud_cnt_reg <= baud_cnt_reg - 16'h0001;
        end
    end

    // a frame starts only while the host holds clear-to-send low
    assign tx_start      = (tx_state_reg == smp_pkg::TX_IDLE) && txq.pop_valid
                           && !cts_n && startup_done_reg;
    assign txq.pop_ready = tx_start;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state_reg <= smp_pkg::TX_IDLE;
            tx_shift_reg <= 10'h3FF;
            tx_bits_reg  <= 4'h0;
        end
        else
        begin
            unique case (tx_state_reg)
                smp_pkg::TX_IDLE:
                begin
                    if (tx_start)
                    begin
                        tx_shift_reg <= {1'b1, txq.pop_data, 1'b0};
                        tx_bits_reg  <= 4'h0;
                        tx_state_reg <= smp_pkg::TX_SHIFT;
                    end
                end
                smp_pkg::TX_SHIFT:
                begin
                    if (baud_tick)
                    begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                        tx_bits_reg  <= tx_bits_reg + 4'h1;
                        if (tx_bits_reg == 4'h9)
                        begin
                            tx_state_reg <= smp_pkg::TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // activity flash; a new byte restarts it, so long bursts stay dark
    assign flashing = (flash_cnt_reg != 32'h0000_0000);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flash_cnt_reg <= 32'h0000_0000;
        end
        else if (tx_start && mode[1])
        begin
            flash_cnt_reg <= FLASH_CYCLES;
        end
        else if (flashing)
        begin
            flash_cnt_reg <= flash_cnt_reg - 32'h0000_0001;
        end
    end

    // pin drivers; status levels are low when lit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_reg <= 1'b0;
            green_reg <= 1'b1;
            red_reg   <= 1'b1;
            blue_reg  <= 1'b1;
            txd_reg   <= 1'b1;
            rts_reg   <= 1'b1;
            dtr_reg   <= 1'b1;
            sel0_reg  <= 1'b0;
            sel1_reg  <= 1'b0;
        end
        else
        begin
            drive_reg <= 1'b1;
            green_reg <= !(mode == smp_pkg::MODE_DATA_IDLE || mode == smp_pkg::MODE_CMD_IDLE);
            red_reg   <= !(mode == smp_pkg::MODE_CMD_IDLE || mode == smp_pkg::MODE_CONNECTING);
            blue_reg  <= !mode[1] || flashing;
            txd_reg   <= (tx_state_reg == smp_pkg::TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
            rts_reg   <= !ctrl_reg[smp_pkg::CTRL_RDY_BIT];
            dtr_reg   <= !ctrl_reg[smp_pkg::CTRL_DTR_BIT];
            sel0_reg  <= ctrl_reg[smp_pkg::CTRL_SEL0_BIT];
            sel1_reg  <= ctrl_reg[smp_pkg::CTRL_SEL1_BIT];
        end
    end

    // green doubles as a strap input, so it floats until the window closes
    assign green_oe_n           = !(drive_reg && startup_done_reg);
    assign green_out            = green_reg;
    assign pins_oe_n            = !drive_reg;
    assign red_n                = red_reg;
    assign blue_n               = blue_reg;
    assign txd                  = txd_reg;
    assign rts_n                = rts_reg;
    assign dtr_n                = dtr_reg;
    assign transceiver_select_0 = sel0_reg;
    assign transceiver_select_1 = sel1_reg;
    assign connect_req          = startup_done_reg && !switch0_n;
    assign factory_restore      = factory_reg;
    assign serial_default       = serdef_reg;

    chk_green_float_startup: assert property (
        @(posedge pclk) disable iff (!presetn)
        !startup_done_reg |-> green_oe_n)
        else $error("green driven before startup window ended");

    chk_pins_float_reset: assert property (
        @(posedge pclk) !presetn |-> pins_oe_n && green_oe_n)
        else $error("pins driven during reset");

    chk_strap_latch_once: assert property (
        @(posedge pclk) disable iff (!presetn)
        startup_done_reg |=> $stable(serdef_reg) && $stable(factory_reg))
        else $error("strap level changed after startup window");

    chk_factory_both_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(startup_done_reg) |-> factory_reg == (!$past(green_in) && !$past(switch0_n)))
        else $error("factory restore does not match straps");

    chk_serial_default_baud: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(startup_done_reg) && serdef_reg |-> baud_div_reg == smp_pkg::BAUD_DIV_DEFAULT)
        else $error("serial default strap did not restore bit rate");

    chk_tx_needs_cts: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(tx_state_reg == smp_pkg::TX_SHIFT) |-> !$past(cts_n))
        else $error("frame started without clear-to-send");

    chk_tx_start_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(tx_state_reg == smp_pkg::TX_SHIFT) |=> !txd ##1 !txd)
        else $error("start bit not driven low");

    chk_led_connected: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == smp_pkg::MODE_CONNECTED && !flashing
        |=> !blue_n && green_out && red_n)
        else $error("connected status pattern wrong");

    chk_flash_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(flashing) |=> blue_n [*8])
        else $error("activity flash ended too soon");

    chk_dtr_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_reg[smp_pkg::CTRL_DTR_BIT] ##1 ctrl_reg[smp_pkg::CTRL_DTR_BIT] |-> !dtr_n)
        else $error("data-terminal-ready not low when set");

endmodule // smp_pin_ctrl

// file: logic/smp_pkg.sv
// Purpose: shared constants of the serial module pin control block
// Assumes: 250 MHz pclk, APB register access with 32-bit data
// Notes:   all timing counts derive from the clock rate
package smp_pkg;

    // clock and timing
    localparam int unsigned CLK_KHZ        = 250_000;
    localparam int unsigned STARTUP_MS     = 500;
    localparam int unsigned FLASH_MS       = 50;
    localparam int unsigned STARTUP_CYCLES = STARTUP_MS * CLK_KHZ;
    localparam int unsigned FLASH_CYCLES   = FLASH_MS * CLK_KHZ;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] BAUD_OFS   = 8'h04;
    localparam logic [7:0] TXDATA_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DTR_BIT  = 2;
    localparam int CTRL_RDY_BIT  = 3;
    localparam int CTRL_SEL0_BIT = 4;
    localparam int CTRL_SEL1_BIT = 5;
    localparam int CTRL_WIDTH    = 6;

    // status register fields
    localparam int STAT_DONE_BIT    = 0;
    localparam int STAT_SERDEF_BIT  = 1;
    localparam int STAT_FACTORY_BIT = 2;
    localparam int STAT_CONNREQ_BIT = 3;
    localparam int STAT_CTS_BIT     = 4;
    localparam int STAT_DSR_BIT     = 5;
    localparam int STAT_RXD_BIT     = 6;
    localparam int STAT_EMPTY_BIT   = 7;
    localparam int STAT_FULL_BIT    = 8;
    localparam int STAT_BUSY_BIT    = 9;

    // reset values
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET       = 6'h00;
    localparam logic [15:0]           BAUD_DIV_DEFAULT = 16'h087A;

    // operating modes shown on the status outputs
    typedef enum logic [1:0] {
        MODE_DATA_IDLE  = 2'b00,
        MODE_CMD_IDLE   = 2'b01,
        MODE_CONNECTING = 2'b10,
        MODE_CONNECTED  = 2'b11
    } smp_mode_t;

    // transmitter states
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } smp_tx_state_t;

endpackage

// file: tb/smp_host_model.sv
// Purpose: host controller model on the uart side of the pin block
// Assumes: frames are 8N1, baud pclk cycles per bit
// Notes:   decodes txd; holds cts off while told to stall
`timescale 1ns/100ps
module smp_host_model (
    // clock
    input  wire logic        pclk,
    // uart lines
    input  wire logic        txd_w,
    input  wire logic        stall,
    input  wire logic [15:0] baud,
    output logic             cts_n,
    output logic             dsr_n,
    output logic             rxd,
    // decoded frames
    output logic [8:0]       rx_word,
    output logic             rx_stb
);
    logic [8:0] w;
    assign cts_n = stall;
    assign dsr_n = 1'b0;
    assign rxd   = 1'b1;
    initial
    begin
        rx_stb  = 1'b0;
        rx_word = '0;
        forever
        begin
            @(negedge txd_w);
            repeat (baud / 2) @(posedge pclk);
            // sample mid-bit: eight data bits lsb first, then the stop bit
            for (int i = 0; i < 9; i++)
            begin
                repeat (baud) @(posedge pclk);
                w[i] = txd_w;
            end
            rx_word <= w;
            rx_stb  <= 1'b1;
            @(posedge pclk);
            rx_stb  <= 1'b0;
        end
    end
endmodule // smp_host_model

// file: tb/smp_tb.sv
// Purpose: self-checking bench of the pin control block
// Assumes: shortened startup and flash counts
// Notes:   txd floats to the pull-up level when undriven; undriven green takes the strap level
`timescale 1ns/100ps
module testbench;
    localparam int unsigned ST = 200;
    localparam int unsigned FL = 20;
    logic        pclk, presetn, psel, penable, pwrite, switch0_n, strap, stall;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, d, seed;
    logic        pready, pslverr, green_out, green_oe_n, red_n, blue_n, txd, rts_n, dtr_n;
    logic        sel0, sel1, pins_oe_n, connect_req, factory_restore, serial_default, e;
    logic        cts_n, dsr_n, rxd, rx_stb;
    logic [8:0]  rx_word;
    logic [8:0]  expq[$];
    int          miscompares = 0, samples_checked = 0, cyc = 0;
    wire         green_w = green_oe_n ? strap : green_out;
    wire         txd_w   = pins_oe_n ? 1'b1 : txd;

    smp_pin_ctrl #(.STARTUP_CYCLES(ST), .FLASH_CYCLES(FL), .FIFO_DEPTH(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .switch0_n(switch0_n), .cts_n(cts_n), .dsr_n(dsr_n), .rxd(rxd), .green_in(green_w),
        .green_out(green_out), .green_oe_n(green_oe_n), .red_n(red_n), .blue_n(blue_n),
        .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n), .transceiver_select_0(sel0),
        .transceiver_select_1(sel1), .pins_oe_n(pins_oe_n), .connect_req(connect_req),
        .factory_restore(factory_restore), .serial_default(serial_default));
    smp_host_model host (.pclk(pclk), .txd_w(txd_w), .stall(stall), .baud(16'h0008),
        .cts_n(cts_n), .dsr_n(dsr_n), .rxd(rxd), .rx_word(rx_word), .rx_stb(rx_stb));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic stop_test;
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [8:0] got, input logic [8:0] exp);
        check_val({23'h0, got}, {23'h0, exp});
    endtask
    // one transfer; holds everything until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run_reset(input logic s, input logic w);
        presetn <= 1'b0; strap <= s; switch0_n <= w;
        repeat (12) @(posedge pclk);
        check_val({31'h0, pins_oe_n & green_oe_n}, 32'h1);
        presetn <= 1'b1;
        repeat (ST - 2) @(posedge pclk);
        check_val({31'h0, green_oe_n}, 32'h1);
        repeat (4) @(posedge pclk);
        check_val({31'h0, green_oe_n}, 32'h0);
        check_val({29'h0, factory_restore, serial_default, connect_req},
                  {29'h0, !s && !w, !s, !w});
        strap <= ~s;
        repeat (8) @(posedge pclk);
        check_val({31'h0, serial_default}, {31'h0, !s});
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            stop_test;
        end
        if (rx_stb === 1'b1)
            if (expq.size() == 0)
                check_byte(rx_word, 9'h1ff);
            else
                check_byte(rx_word, expq.pop_front());
    end
    initial
    begin
        presetn = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; switch0_n = 1'b1; strap = 1'b1; stall = 1'b0;
        seed = 32'h48aa_ac92;
        run_reset(1'b1, 1'b1);
        run_reset(1'b0, 1'b1);
        run_reset(1'b0, 1'b0);
        apb(1'b0, smp_pkg::BAUD_OFS, 32'h0);
        check_val(r, 32'h0000_087a);
        apb(1'b0, 8'h10, 32'h0);
        check_val({31'h0, e}, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            seed = lfsr(seed);
            d = {26'h0, seed[5:2], m[1:0]};
            apb(1'b1, smp_pkg::CTRL_OFS, d);
            // pin registers follow ctrl one edge later, so let that edge settle first
            @(posedge pclk);
            check_val({28'h0, green_w, red_n, blue_n, dtr_n},
                      {28'h0, m[1], !(m == 1 || m == 2), !m[1], !d[2]});
            check_val({29'h0, rts_n, sel0, sel1}, {29'h0, !d[3], d[4], d[5]});
            apb(1'b0, smp_pkg::CTRL_OFS, 32'h0);
            check_val(r, d);
        end
        apb(1'b1, smp_pkg::BAUD_OFS, 32'h0000_0008);
        stall <= 1'b1;
        apb(1'b1, smp_pkg::CTRL_OFS, 32'h0000_0003);
        for (int i = 0; i < 9; i++)
        begin
            seed = lfsr(seed);
            expq.push_back({1'b1, seed[7:0]});
            if (i < 8)
                apb(1'b1, smp_pkg::TXDATA_OFS, seed);
        end
        apb(1'b0, smp_pkg::STATUS_OFS, 32'h0);
        check_val(r, 32'h0000_016f);
        check_val({31'h0, txd_w}, 32'h1);
        fork
            apb(1'b1, smp_pkg::TXDATA_OFS, {24'h0, expq[8][7:0]});
            begin
                repeat (30) @(posedge pclk);
                check_val({31'h0, pready}, 32'h0);
                stall <= 1'b0;
            end
        join
        for (int n = 0; n < 200 && txd_w !== 1'b0; n++) @(posedge pclk);
        repeat (3) @(posedge pclk);
        check_val({31'h0, blue_n}, 32'h1);
        repeat (FL + 20) @(posedge pclk);
        check_val({31'h0, blue_n}, 32'h0);
        for (int n = 0; n < 3000 && expq.size() > 0; n++) @(posedge pclk);
        repeat (20) @(posedge pclk);
        apb(1'b0, smp_pkg::STATUS_OFS, 32'h0);
        check_val({30'h0, r[9], r[7]}, 32'h1);
        check_val(expq.size(), 32'h0);
        stop_test;
    end
endmodule // testbench
